/* File: bus_strobe_pkg.sv */
// Package of constants and types for the multiplexed bus strobe block
package bus_strobe_pkg;

    // ****************************************************************
    // Bus cycle kinds
    // ****************************************************************
    localparam logic [1:0] CYC_MEM_READ  = 2'h0;  // Memory read
    localparam logic [1:0] CYC_MEM_WRITE = 2'h1;  // Memory write
    localparam logic [1:0] CYC_IO_READ   = 2'h2;  // I/O read
    localparam logic [1:0] CYC_IO_WRITE  = 2'h3;  // I/O write

    // ****************************************************************
    // Width codes: {upper_byte_enable_n, a0}
    // ****************************************************************
    localparam logic [1:0] WID_WORD    = 2'h0;    // Both low
    localparam logic [1:0] WID_HIGH    = 2'h1;    // High byte D15-D8
    localparam logic [1:0] WID_LOW     = 2'h2;    // Low byte D7-D0
    localparam logic [1:0] WID_REFRESH = 2'h3;    // Refresh

    // ****************************************************************
    // Reset values and timing
    // ****************************************************************
    localparam logic       STRAP_RST     = 1'h1;  // Pull-up default
    localparam int         SYNC_STAGES   = 2;     // Ready synchroniser
    localparam int         CLK_NS        = 10;    // Clock period
    localparam int         BUS_PHASE_NS  = 10;    // One T-state
    localparam int         PHASE_CYCLES  =
        (BUS_PHASE_NS + CLK_NS - 1) / CLK_NS;   // Cycles per T-state

    // ****************************************************************
    // Bus state machine, one-hot
    // ****************************************************************
    typedef enum logic [5:0] {
        ST_IDLE = 6'h01,   // Bus idle
        ST_T1   = 6'h02,   // Address phase
        ST_T2   = 6'h04,   // Strobe begins
        ST_T3   = 6'h08,   // Ready sampled
        ST_TW   = 6'h10,   // Wait state
        ST_T4   = 6'h20    // Cycle ends
    } bus_state_t;

endpackage

/* File: ready_sync_if.sv */
// Interface carrying ready inputs and the resolved ready level
interface ready_sync_if;
    logic async_ready_in;   // Raw asynchronous ready
    logic sync_ready_in;    // Synchronous ready
    logic ready;            // Resolved ready
    modport src (output async_ready_in, output sync_ready_in,
                 input ready);
    modport sync (input async_ready_in, input sync_ready_in,
                  output ready);
endinterface

/* File: ready_sync.sv */
// Synchroniser and selector for the two ready inputs
module ready_sync
    import bus_strobe_pkg::*;
(
    // Clock and reset
    input  wire logic  mclk_i,
    input  wire logic  sys_rst_i,
    // Ready signals
    ready_sync_if.sync rdy
);

    // ****************************************************************
    // Two-flop synchroniser for the asynchronous ready
    // ****************************************************************
    logic meta_ff;          // First stage, read only by second
    logic async_ready_in_ff;          // Second stage, safe to use

    // Rising edge taken at any time
    always_ff @(posedge mclk_i)
    begin
        if (sys_rst_i)
        begin
            meta_ff <= 1'h0;
            async_ready_in_ff <= 1'h0;
        end
        else
        begin
            meta_ff <= rdy.async_ready_in;  // see RQ14
            async_ready_in_ff <= meta_ff;
        end
    end

    // Async ready high ends waits; low yields to sync ready
    always_comb
    begin
        rdy.ready = async_ready_in_ff | rdy.sync_ready_in;  // see RQ16, RQ17
    end

endmodule

/* File: bus_strobe_ctrl.sv */
// Strobe, byte-enable and address latch control for the muxed bus
//
// Contract
// RQ1: Enable and A0 encode word, bytes, refresh.
// RQ2: Byte enable asserted T1 through T3, waits.
// RQ3: Byte enable floats in hold or reset.
// RQ4: Strap high lets disable bit drop address.
// RQ5: Weak pull-up makes strap read high.
// RQ6: Strap low always drives address and data.
// RQ7: Test interface turns pin into TRST input.
// RQ8: Write strobe low in T2, T3, waits.
// RQ9: Write strobe floats in hold or reset.
// RQ10: Read strobe on reads, floats hold/reset.
// RQ11: Address latch pulses while address driven.
// RQ12: Address latch tri-stated in emulation mode.
// RQ13: Address latch driven in hold and reset.
// RQ14: Async ready rising edge synchronised internally.
// RQ15: Partner drops async ready synchronously.
// RQ16: Async ready high means no waits.
// RQ17: Async ready low yields to sync ready.
// RQ18: Address in t1, data t2 to t4.
// RQ19: Strap sampled at reset release, held.
module bus_strobe_ctrl
    import bus_strobe_pkg::*;
(
    // Clock and reset
    input  wire logic        mclk_i,
    input  wire logic        sys_rst_i,
    // Cycle request from the core
    input  wire logic        cyc_req_i,
    input  wire logic [1:0]  cyc_kind_i,
    input  wire logic [1:0]  cyc_width_i,
    input  wire logic        cyc_chip_sel_i,
    input  wire logic        upper_disable_i,
    input  wire logic        lower_disable_i,
    input  wire logic        cyc_upper_i,
    output logic             cyc_busy_o,
    output logic             cyc_done_o,
    // Mode inputs
    input  wire logic        hold_grant_i,
    input  wire logic        test_enable_i,
    input  wire logic        emulation_isolate_mode_i,
    // Ready inputs
    input  wire logic        async_ready_in_i,
    input  wire logic        sync_ready_in_i,
    // Byte-enable / strap / TRST pin
    input  wire logic        upper_byte_enable_n_i,
    output logic             upper_byte_enable_n_o,
    output logic             upper_byte_enable_n_oe_n_o,
    output logic             pullup_en_o,
    output logic             trst_o,
    // Strobes and latch
    output logic             wr_n_o,
    output logic             wr_n_oe_n_o,
    output logic             rd_n_o,
    output logic             rd_n_oe_n_o,
    output logic             addr_latch_o,
    output logic             addr_latch_oe_n_o,
    // Bus phase to the data path
    output logic             a0_o,
    output logic             addr_drive_o,
    output logic             data_phase_o,
    output logic             strap_o
);

    // ****************************************************************
    // Declarations
    // ****************************************************************
    bus_state_t state_ff;        // Bus state
    bus_state_t nxt_state;       // Next bus state
    logic [1:0] kind_ff;         // Latched cycle kind
    logic [1:0] width_ff;        // Latched width code
    logic       drop_addr;       // Address phase suppressed
    logic       strap_ff;        // Captured strap level
    logic       rst_d_ff;        // Reset delayed one cycle
    logic       floated;         // Hold or reset floats pins
    logic       is_write;        // Latched cycle writes
    ready_sync_if rdy_if ();     // Ready path

    // ****************************************************************
    // Cycle decodes
    // ****************************************************************
    // Decode: kind writes
    function automatic logic kind_writes(input logic [1:0] k);
        kind_writes = (k == CYC_MEM_WRITE) || (k == CYC_IO_WRITE);
    endfunction

    // Strobe pins float while hold is granted or reset is applied
    assign floated  = hold_grant_i | sys_rst_i;
    // Write strobe or read strobe for the latched cycle
    assign is_write = kind_writes(kind_ff);
    // Strap high honours the selected disable bit; strap low never
    // drops the address, whatever the disable bits say
    assign drop_addr = strap_ff && cyc_chip_sel_i &&
        (cyc_upper_i ? upper_disable_i
                     : lower_disable_i);  // see RQ4, RQ6

    // ****************************************************************
    // Ready synchroniser
    // ****************************************************************
    // The state machine sees one resolved ready level
    assign rdy_if.async_ready_in = async_ready_in_i;
    assign rdy_if.sync_ready_in  = sync_ready_in_i;

    ready_sync u_ready_sync (
        .mclk_i    (mclk_i),
        .sys_rst_i (sys_rst_i),
        .rdy       (rdy_if)
    );

    // ****************************************************************
    // Strap capture
    // ****************************************************************
    // Sample the pin at the first edge after reset release
    always_ff @(posedge mclk_i)
    begin
        rst_d_ff <= sys_rst_i;
        if (sys_rst_i)
        begin
            // Pull-up level until the pin is seen
            strap_ff <= STRAP_RST;
        end
        else if (rst_d_ff && !test_enable_i)
        begin
            // One sample only; the test port owns the pin otherwise
            strap_ff <= upper_byte_enable_n_i;  // see RQ19
        end
    end

    // ****************************************************************
    // Bus state machine
    // ****************************************************************
    // Next state from request and ready
    always_comb
    begin
        nxt_state = state_ff;
        case (state_ff)
            ST_IDLE:
            begin
                // Hold refuses new requests
                if (cyc_req_i && !hold_grant_i)
                begin
                    nxt_state = ST_T1;
                end
            end
            ST_T1:   nxt_state = ST_T2;
            ST_T2:   nxt_state = ST_T3;
            ST_T3, ST_TW:
            begin
                // Wait until ready is seen
                nxt_state = rdy_if.ready ? ST_T4 : ST_TW;
            end
            ST_T4:   nxt_state = ST_IDLE;
            default: nxt_state = ST_IDLE;
        endcase
    end

    // State register
    always_ff @(posedge mclk_i)
    begin
        if (sys_rst_i)
        begin
            // Reset returns to idle
            state_ff <= ST_IDLE;
        end
        else
        begin
            // Advance one state per clock
            state_ff <= nxt_state;
        end
    end

    // Latch the cycle attributes at the start
    always_ff @(posedge mclk_i)
    begin
        if (sys_rst_i)
        begin
            // Refresh code keeps the byte enable off
            kind_ff  <= CYC_MEM_READ;
            width_ff <= WID_REFRESH;
        end
        else if (state_ff == ST_IDLE && nxt_state == ST_T1)
        begin
            // Taken only on the idle-to-T1 step
            kind_ff  <= cyc_kind_i;
            width_ff <= cyc_width_i;
        end
    end

    // ****************************************************************
    // Pin outputs
    // ****************************************************************
    // Byte enable and A0 from the width code
    always_ff @(posedge mclk_i)
    begin
        if (sys_rst_i)
        begin
            // Pin released during reset
            upper_byte_enable_n_o      <= 1'h1;
            upper_byte_enable_n_oe_n_o <= 1'h1;  // see RQ3
            a0_o                       <= 1'h0;
        end
        else
        begin
            // Asserted from T1 through T3 and waits
            if (nxt_state == ST_T1 || nxt_state == ST_T2 ||
                nxt_state == ST_T3 || nxt_state == ST_TW)
            begin
                upper_byte_enable_n_o <= (nxt_state == ST_T1)
                    ? cyc_width_i[1] : width_ff[1];  // see RQ1, RQ2
                a0_o <= (nxt_state == ST_T1)
                    ? cyc_width_i[0] : width_ff[0];  // see RQ1
            end
            else
            begin
                // Off in T4 and idle
                upper_byte_enable_n_o <= 1'h1;
            end
            // Float in hold, yield the pin to the test port
            upper_byte_enable_n_oe_n_o <=
                hold_grant_i | test_enable_i;  // see RQ3, RQ7
        end
    end

    // Pull-up stays on so an open strap reads high
    always_ff @(posedge mclk_i)
    begin
        pullup_en_o <= 1'h1;  // see RQ5
        // Test port reads the pin as its reset line
        trst_o <= test_enable_i ? upper_byte_enable_n_i
                                : 1'h1;  // see RQ7
        strap_o <= strap_ff;
    end

    // Write and read strobes
    always_ff @(posedge mclk_i)
    begin
        if (floated)
        begin
            // Both strobes float in hold or reset
            wr_n_o      <= 1'h1;
            rd_n_o      <= 1'h1;
            wr_n_oe_n_o <= 1'h1;  // see RQ9
            rd_n_oe_n_o <= 1'h1;  // see RQ10
        end
        else
        begin
            // Driven in every other cycle
            wr_n_oe_n_o <= 1'h0;
            rd_n_oe_n_o <= 1'h0;
            // Active in T2, T3 and waits
            wr_n_o <= !((nxt_state == ST_T2 || nxt_state == ST_T3 ||
                         nxt_state == ST_TW) && is_write);  // see RQ8
            rd_n_o <= !((nxt_state == ST_T2 || nxt_state == ST_T3 ||
                         nxt_state == ST_TW) && !is_write); // see RQ10
        end
    end

    // Address latch and bus phase
    always_ff @(posedge mclk_i)
    begin
        if (sys_rst_i)
        begin
            // Latch stays driven, low, in reset
            addr_latch_o      <= 1'h0;
            addr_latch_oe_n_o <= 1'h0;  // see RQ13
            addr_drive_o      <= 1'h0;
            data_phase_o      <= 1'h0;
        end
        else
        begin
            // Pulse in T1; falls as address stays valid
            addr_latch_o <= (nxt_state == ST_T1);  // see RQ11
            addr_latch_oe_n_o <= emulation_isolate_mode_i; // see RQ12
            addr_drive_o <= (nxt_state == ST_T1) &&
                !drop_addr;  // see RQ18
            data_phase_o <= (nxt_state == ST_T2 || nxt_state == ST_T3 ||
                             nxt_state == ST_TW ||
                             nxt_state == ST_T4);  // see RQ18
        end
    end

    // ****************************************************************
    // Core handshake
    // ****************************************************************
    // Handshake to the core
    always_ff @(posedge mclk_i)
    begin
        if (sys_rst_i)
        begin
            // Quiet during reset
            cyc_busy_o <= 1'h0;
            cyc_done_o <= 1'h0;
        end
        else
        begin
            // Busy from T1 through T4, done in T4 only
            cyc_busy_o <= (nxt_state != ST_IDLE);
            cyc_done_o <= (nxt_state == ST_T4);
        end
    end

endmodule

/* File: memory_ready_model.sv */
// Memory-side model that answers on the async ready line
module memory_ready_model
(
    // Clock and strobes
    input  wire logic       mclk_i,
    input  wire logic       strobe_n_i,
    // Answer speed
    input  wire logic       fast_i,
    input  wire logic [3:0] wait_i,
    // Ready back to the controller
    output logic            async_ready_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] cnt_ff;  // Cycles since the strobe fell
    initial async_ready_o = 1'h0;
    // Count strobe-low cycles, saturating
    always @(posedge mclk_i)
    begin
        if (strobe_n_i)
            cnt_ff <= 4'h0;
        else if (cnt_ff != 4'hF)
            cnt_ff <= cnt_ff + 4'h1;
    end
    // Rise between edges, fall only on an edge
    always @(posedge mclk_i)
    begin
        if (fast_i)
            async_ready_o <= 1'h1;     // Tied high
        else if (strobe_n_i)
            async_ready_o <= 1'h0;
        else if (cnt_ff == wait_i)
            async_ready_o <= #3 1'h1;  // Off the edge
    end
endmodule

/* File: bus_strobe_checker.sv */
// Port assertions for the bus strobe controller
module bus_strobe_checker
(
    // Clock and reset
    input wire logic       mclk_i,
    input wire logic       sys_rst_i,
    // Request side
    input wire logic       cyc_req_i,
    input wire logic [1:0] cyc_kind_i,
    input wire logic [1:0] cyc_width_i,
    input wire logic       cyc_chip_sel_i,
    input wire logic       upper_disable_i,
    input wire logic       lower_disable_i,
    input wire logic       cyc_upper_i,
    input wire logic       cyc_busy_o,
    input wire logic       cyc_done_o,
    // Modes and ready
    input wire logic       hold_grant_i,
    input wire logic       emulation_isolate_mode_i,
    input wire logic       async_ready_in_i,
    input wire logic       sync_ready_in_i,
    // Pins
    input wire logic       upper_byte_enable_n_o,
    input wire logic       upper_byte_enable_n_oe_n_o,
    input wire logic       wr_n_o,
    input wire logic       wr_n_oe_n_o,
    input wire logic       rd_n_o,
    input wire logic       rd_n_oe_n_o,
    input wire logic       addr_latch_o,
    input wire logic       addr_latch_oe_n_o,
    input wire logic       a0_o,
    input wire logic       addr_drive_o,
    input wire logic       data_phase_o,
    input wire logic       strap_o
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (sys_rst_i);
    // Steps of a bus cycle
    sequence s_t1; cyc_busy_o && !data_phase_o; endsequence
    sequence s_t2; !addr_latch_o && data_phase_o && (wr_n_o ^ rd_n_o);
    endsequence
    sequence s_fast; async_ready_in_i ##1
        ($rose(addr_latch_o) && async_ready_in_i) ##1 async_ready_in_i[*2];
    endsequence
    a_float_hold_rst: assert property (disable iff (1'h0)
        sys_rst_i || hold_grant_i |=> wr_n_oe_n_o && rd_n_oe_n_o
        && upper_byte_enable_n_oe_n_o) else $error("strobes not floated");
    a_latch_drive: assert property (disable iff (1'h0)
        1 |=> addr_latch_oe_n_o == $past(emulation_isolate_mode_i))
        else $error("latch drive wrong");
    a_req_latch: assert property (!cyc_busy_o && cyc_req_i
        && !hold_grant_i |-> ##[1:2] addr_latch_o) else $error("no latch");
    a_cycle_walk: assert property ($rose(addr_latch_o) |->
        s_t1 ##1 s_t2) else $error("T1 T2 order wrong");
    a_width_code: assert property ($rose(addr_latch_o) |->
        {upper_byte_enable_n_o, a0_o} == cyc_width_i) else $error("width");
    a_enable_held: assert property (cyc_busy_o && $past(cyc_busy_o)
        && !cyc_done_o |-> $stable(upper_byte_enable_n_o))
        else $error("byte enable moved");
    a_strobe_kind: assert property (data_phase_o && !cyc_done_o
        |-> wr_n_o == !cyc_kind_i[0] && rd_n_o == cyc_kind_i[0])
        else $error("strobe kind wrong");
    a_no_wait: assert property (s_fast |=> cyc_done_o)
        else $error("wait with ready high");
    a_addr_select: assert property ($rose(addr_latch_o) |->
        addr_drive_o == !(strap_o && cyc_chip_sel_i && (cyc_upper_i ?
        upper_disable_i : lower_disable_i))) else $error("address drive");
    a_wait_low: assert property ((!async_ready_in_i &&
        !sync_ready_in_i)[*4] |=> !cyc_done_o) else $error("done unready");
    a_strap_hold: assert property (!$past(sys_rst_i, 3)
        && !$past(sys_rst_i, 2) && !$past(sys_rst_i)
        |-> $stable(strap_o)) else $error("strap");
endmodule
bind bus_strobe_ctrl bus_strobe_checker u_chk (.*);

/* File: test_muxed_bus_strobe_control.sv */
// Self-checking bench for the bus strobe controller
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin fails++; \
    $display("ERROR %0t got %h want %h", $time, a, b); end end
module test_muxed_bus_strobe_control;
    timeunit 1ns;
    timeprecision 1ps;
    // Design inputs
    logic mclk_i = 1'h0, sys_rst_i = 1'h1, cyc_req_i = 1'h0;
    logic [1:0] cyc_kind_i = 2'h0, cyc_width_i = 2'h0;
    logic cyc_chip_sel_i = 1'h0, upper_disable_i = 1'h0;
    logic lower_disable_i = 1'h0, cyc_upper_i = 1'h0;
    logic hold_grant_i = 1'h0, test_enable_i = 1'h0;
    logic emulation_isolate_mode_i = 1'h0, sync_ready_in_i = 1'h0;
    wire  logic async_ready_in_i, upper_byte_enable_n_i;
    // Design outputs
    logic cyc_busy_o, cyc_done_o, upper_byte_enable_n_o, pullup_en_o;
    logic upper_byte_enable_n_oe_n_o, trst_o, wr_n_o, wr_n_oe_n_o;
    logic rd_n_o, rd_n_oe_n_o, addr_latch_o, addr_latch_oe_n_o;
    logic a0_o, addr_drive_o, data_phase_o, strap_o;
    // Bench state
    logic       pull_lvl = 1'h1, exp_strap, fast = 1'h1;
    logic [3:0] wait_n = 4'h3;
    logic [2:0] exp_q[$], e;
    int         fails = 0, checks = 0, seed = 32'h3B7C, n, n0;
    logic [31:0] r;
    // Pin level: pad driver, else pull-up or strap resistor
    assign upper_byte_enable_n_i = upper_byte_enable_n_oe_n_o ?
        pull_lvl : upper_byte_enable_n_o;
    always #5 mclk_i = ~mclk_i;
    bus_strobe_ctrl u_dut (.*);
    memory_ready_model u_mem (.mclk_i(mclk_i),
        .strobe_n_i(wr_n_o & rd_n_o), .fast_i(fast), .wait_i(wait_n),
        .async_ready_o(async_ready_in_i));
    // Compare T1 outputs with the oldest note
    always @(posedge mclk_i)
    begin
        if (addr_latch_o === 1'h1)
        begin
            e = exp_q.size() ? exp_q.pop_front() : 3'h7;
            `CHK({upper_byte_enable_n_o, a0_o, addr_drive_o}, e)
        end
    end
    task automatic tick(input int c);
        repeat (c) @(posedge mclk_i);
    endtask
    task automatic end_of_test;
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    // Bounded wait on busy or done, counting edges
    task automatic wait_hi(input bit on_done, output int c);
        c = 0;
        while ((on_done ? cyc_done_o : cyc_busy_o) !== 1'h1)
        begin
            @(posedge mclk_i);
            c++;
            if (c > 60)
            begin
                fails++;
                end_of_test();
            end
        end
    endtask
    // One bus cycle with random select bits
    task automatic bus_cycle(input logic [1:0] kind, width, output int c);
        int m;
        @(posedge mclk_i);
        r = $random(seed);
        cyc_kind_i <= kind;
        cyc_width_i <= width;
        cyc_chip_sel_i <= r[0];
        cyc_upper_i <= r[1];
        upper_disable_i <= r[2];
        lower_disable_i <= r[3];
        exp_q.push_back({width, !(exp_strap && r[0] && (r[1] ? r[2] : r[3]))});
        cyc_req_i <= 1'h1;
        wait_hi(1'b0, m);
        cyc_req_i <= 1'h0;
        wait_hi(1'b1, c);
    endtask
    // Reset with a chosen strap level
    task automatic do_reset(input logic lvl);
        @(posedge mclk_i);
        sys_rst_i <= 1'h1;
        pull_lvl <= lvl;
        exp_strap = lvl;
        tick(2);
        `CHK({wr_n_oe_n_o, rd_n_oe_n_o, upper_byte_enable_n_oe_n_o, addr_latch_oe_n_o}, 4'hE)
        sys_rst_i <= 1'h0;
        tick(3);
        `CHK({strap_o, pullup_en_o}, {lvl, 1'h1})
    endtask
    initial
    begin
        do_reset(1'h1);
        // Every kind and width, ready tied high
        for (int k = 0; k < 16; k++)
            bus_cycle(k[3:2], k[1:0], n0);
        // No waits: done three edges after busy is seen
        `CHK(n0, 3)
        fast <= 1'h0;
        bus_cycle(2'h1, 2'h0, n);
        `CHK(n > n0, 1'h1)
        sync_ready_in_i <= 1'h1;
        wait_n <= 4'hC;
        bus_cycle(2'h2, 2'h3, n);
        `CHK(n, n0)
        // Hold refuses requests and floats strobes
        hold_grant_i <= 1'h1;
        cyc_req_i <= 1'h1;
        tick(3);
        `CHK({cyc_busy_o, wr_n_oe_n_o, rd_n_oe_n_o, upper_byte_enable_n_oe_n_o, addr_latch_oe_n_o}, 5'h0E)
        hold_grant_i <= 1'h0;
        cyc_req_i <= 1'h0;
        emulation_isolate_mode_i <= 1'h1;
        tick(2);
        `CHK(addr_latch_oe_n_o, 1'h1)
        emulation_isolate_mode_i <= 1'h0;
        test_enable_i <= 1'h1;
        for (int k = 0; k < 2; k++)
        begin
            pull_lvl <= k[0];
            tick(3);
            `CHK(trst_o, k[0])
        end
        test_enable_i <= 1'h0;
        do_reset(1'h0);
        for (int k = 0; k < 6; k++)
            bus_cycle(k[1:0], 2'h0, n);
        tick(2);
        `CHK(exp_q.size(), 0)
        end_of_test();
    end
endmodule
